// ### aic_pkg.sv
// Shared constants and types for the light-sensor interrupt and sleep block.
package aic_pkg;

  localparam logic [7:0] STATUS_ADDR = 8'h93;
  localparam logic [7:0] IRQ_SLEEP_CFG_ADDR = 8'hAB;
  localparam logic [7:0] AUTOZERO_CFG_ADDR = 8'hD6;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hDD;

  localparam int SATURATION_BIT = 7;
  localparam int LIGHT_IRQ_BIT = 4;
  localparam int READ_CLEAR_BIT = 7;
  localparam int SLEEP_AFTER_IRQ_BIT = 4;
  localparam int START_MODE_BIT = 7;

  localparam logic [7:0] FLAG_MASK = 8'h90;
  localparam logic [7:0] IRQ_SLEEP_CFG_RST = 8'h0C;
  localparam logic [7:0] IRQ_SLEEP_CFG_WMASK = 8'h9F;
  localparam logic [7:0] AUTOZERO_CFG_RST = 8'h7F;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_WMASK = 8'h90;

  localparam logic [6:0] PERIOD_NEVER = 7'h00;
  localparam logic [6:0] PERIOD_FIRST_ONLY = 7'h7F;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aic_reg_req_type;

  typedef struct packed {
    logic sat_event;
    logic light_event;
    logic cycle_start;
    logic cycle_end;
  } aic_meas_type;

  typedef struct packed {
    logic int_o;
    logic int_oe;
  } aic_pin_type;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] irq_sleep_cfg;
    logic [7:0] autozero_cfg;
    logic [7:0] irq_enable;
    logic [7:0] rdata;
    logic sleep;
    logic first_pending;
    logic [6:0] iter_cnt;
    logic autozero_run;
    logic start_from_prev;
  } aic_state_type;

endpackage

// ### aic_ctrl.sv
// Interrupt, sleep-after-interrupt and auto-zero scheduling control.
// How it works
// - Read-clear bit set: status read clears flags.
// - Sleep bit and interrupt: power down at cycle end.
// - Oscillator runs with power on, stops in sleep.
// - Start mode 0: offset search starts at zero.
// - Start mode 1: search starts at previous offset.
// - Auto-zero runs every nth measurement iteration.
// - Period 0 never; 7Fh only first cycle.
// - Saturation enable gates saturation interrupt source.
// - Light enable gates measurement interrupt source.
// - Previous start faster average; zero better worst.
// - Saturation flag set on saturation, write-1 clears.
// - Measurement flag shows interrupt, write-1 clears.
`timescale 1ns/1ps

module aic_ctrl
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire aic_pkg::aic_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire logic power_on,
  input wire aic_pkg::aic_meas_type meas,
  output aic_pkg::aic_pin_type int_pin,
  input wire logic int_i,
  output logic osc_run,
  output logic autozero_run,
  output logic start_from_prev
);

  logic rst_meta_b_r;
  logic rst_sync_b_r;
  aic_pkg::aic_state_type st_r;
  aic_pkg::aic_state_type st_nxt;
  logic irq_active;
  logic read_status;
  logic [7:0] w1c;
  logic [7:0] set_flags;
  logic [7:0] rd_clear;

  // Asynchronous assert, synchronous release of the reset.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b_r <= 1'h0;
      rst_sync_b_r <= 1'h0;
    end
    else
    begin
      rst_meta_b_r <= 1'h1;
      rst_sync_b_r <= rst_meta_b_r;
    end
  end

  function automatic logic wr_hit(input aic_pkg::aic_reg_req_type r,
                                  input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // Enabled flags drive the pin; the pin itself is open drain.
  assign irq_active = |(st_r.status & st_r.irq_enable &
                        aic_pkg::FLAG_MASK);
  assign read_status = reg_req.rd && (reg_req.addr == aic_pkg::STATUS_ADDR);

  always_comb
  begin
    st_nxt = st_r;
    set_flags = 8'h00;
    set_flags[aic_pkg::SATURATION_BIT] = meas.sat_event;
    set_flags[aic_pkg::LIGHT_IRQ_BIT] = meas.light_event;
    w1c = 8'h00;
    if (wr_hit(reg_req, aic_pkg::STATUS_ADDR))
    begin
      w1c = reg_req.wdata & aic_pkg::FLAG_MASK;
    end
    rd_clear = 8'h00;
    if (read_status && st_r.irq_sleep_cfg[aic_pkg::READ_CLEAR_BIT])
    begin
      rd_clear = aic_pkg::FLAG_MASK;
    end
    // A new event in the clearing cycle survives the clear.
    st_nxt.status = ((st_r.status & ~(w1c | rd_clear)) | set_flags) &
                    aic_pkg::FLAG_MASK;

    if (wr_hit(reg_req, aic_pkg::IRQ_SLEEP_CFG_ADDR))
    begin
      // Reserved low nibble is stored but steers nothing.
      st_nxt.irq_sleep_cfg = (reg_req.wdata &
                              aic_pkg::IRQ_SLEEP_CFG_WMASK);
    end
    if (wr_hit(reg_req, aic_pkg::AUTOZERO_CFG_ADDR))
    begin
      st_nxt.autozero_cfg = reg_req.wdata;
    end
    if (wr_hit(reg_req, aic_pkg::IRQ_ENABLE_ADDR))
    begin
      st_nxt.irq_enable = reg_req.wdata & aic_pkg::IRQ_ENABLE_WMASK;
    end

    case (reg_req.addr)
      aic_pkg::STATUS_ADDR: st_nxt.rdata = st_r.status;
      aic_pkg::IRQ_SLEEP_CFG_ADDR: st_nxt.rdata = st_r.irq_sleep_cfg;
      aic_pkg::AUTOZERO_CFG_ADDR: st_nxt.rdata = st_r.autozero_cfg;
      aic_pkg::IRQ_ENABLE_ADDR: st_nxt.rdata = st_r.irq_enable;
      default: st_nxt.rdata = 8'h00;
    endcase

    // Sleep is entered only at a cycle end and leaves no trace in the
    // registers; it ends at the first clock edge after the pin is released.
    if (!power_on || !st_r.irq_sleep_cfg[aic_pkg::SLEEP_AFTER_IRQ_BIT] ||
        int_i)
    begin
      st_nxt.sleep = 1'h0;
    end
    else if (meas.cycle_end && !int_i)
    begin
      st_nxt.sleep = 1'h1;
    end

    // Auto-zero scheduling at each measurement start.
    st_nxt.autozero_run = 1'h0;
    st_nxt.start_from_prev =
      st_r.autozero_cfg[aic_pkg::START_MODE_BIT];
    if (!power_on)
    begin
      st_nxt.first_pending = 1'h1;
      st_nxt.iter_cnt = 7'h00;
    end
    else if (meas.cycle_start)
    begin
      st_nxt.first_pending = 1'h0;
      case (st_r.autozero_cfg[6:0])
        aic_pkg::PERIOD_NEVER:
        begin
          st_nxt.autozero_run = 1'h0;
        end
        aic_pkg::PERIOD_FIRST_ONLY:
        begin
          st_nxt.autozero_run = st_r.first_pending;
        end
        default:
        begin
          st_nxt.autozero_run = (st_r.iter_cnt == 7'h00);
          if (st_r.iter_cnt >= st_r.autozero_cfg[6:0] - 7'h01)
          begin
            st_nxt.iter_cnt = 7'h00;
          end
          else
          begin
            st_nxt.iter_cnt = st_r.iter_cnt + 7'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b_r)
  begin
    if (!rst_sync_b_r)
    begin
      st_r.status <= 8'h00;
      st_r.irq_sleep_cfg <= aic_pkg::IRQ_SLEEP_CFG_RST;
      st_r.autozero_cfg <= aic_pkg::AUTOZERO_CFG_RST;
      st_r.irq_enable <= aic_pkg::IRQ_ENABLE_RST;
      st_r.rdata <= 8'h00;
      st_r.sleep <= 1'h0;
      st_r.first_pending <= 1'h1;
      st_r.iter_cnt <= 7'h00;
      st_r.autozero_run <= 1'h0;
      st_r.start_from_prev <= 1'h0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign int_pin = '{int_o: 1'h0, int_oe: irq_active};
  // The live pin gates the oscillator too, so a released interrupt restarts
  // it in that very cycle instead of one edge later.
  assign osc_run = power_on &&
    !(st_r.sleep && !int_i &&
      st_r.irq_sleep_cfg[aic_pkg::SLEEP_AFTER_IRQ_BIT]);
  assign autozero_run = st_r.autozero_run;
  assign start_from_prev = st_r.start_from_prev;

  property p_read_clear;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (read_status && st_r.irq_sleep_cfg[7] && !meas.sat_event &&
     !meas.light_event) |=> (st_r.status == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status not cleared by read");

  property p_sleep_entry;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (meas.cycle_end && power_on && st_r.irq_sleep_cfg[4] && !int_i)
    |=> st_r.sleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("no sleep after interrupt at cycle end");

  property p_osc_off;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (power_on && (int_i ||
     !st_r.irq_sleep_cfg[aic_pkg::SLEEP_AFTER_IRQ_BIT])) |-> osc_run;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator stopped while it must run");

  property p_wake;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (st_r.sleep && int_i) |=> !st_r.sleep;
  endproperty
  a_wake: assert property (p_wake)
    else $error("device did not wake on released interrupt");

  property p_start_mode;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    ##1 (start_from_prev == $past(st_r.autozero_cfg[7]));
  endproperty
  a_start_mode: assert property (p_start_mode)
    else $error("start mode output wrong");

  property p_never;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (st_r.autozero_cfg[6:0] == 7'h00) |=> !autozero_run;
  endproperty
  a_never: assert property (p_never)
    else $error("auto-zero ran with period zero");

  property p_first_only;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (meas.cycle_start && power_on && !st_r.first_pending &&
     st_r.autozero_cfg[6:0] == 7'h7F) |=> !autozero_run;
  endproperty
  a_first_only: assert property (p_first_only)
    else $error("auto-zero ran after first cycle");

  property p_every_nth;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (meas.cycle_start && power_on && st_r.iter_cnt == 7'h00 &&
     st_r.autozero_cfg[6:0] != 7'h00 && st_r.autozero_cfg[6:0] != 7'h7F)
    |=> autozero_run;
  endproperty
  a_every_nth: assert property (p_every_nth)
    else $error("auto-zero missed its iteration");

  property p_sat_set;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    meas.sat_event |=> st_r.status[7];
  endproperty
  a_sat_set: assert property (p_sat_set)
    else $error("saturation flag not set");

  property p_w1c;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (reg_req.wr && reg_req.addr == aic_pkg::STATUS_ADDR &&
     reg_req.wdata[aic_pkg::LIGHT_IRQ_BIT] && !meas.light_event)
    |=> !st_r.status[aic_pkg::LIGHT_IRQ_BIT];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("light flag not cleared by write");

  property p_pin;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    int_pin.int_oe == ((st_r.status[7] && st_r.irq_enable[7]) ||
                       (st_r.status[4] && st_r.irq_enable[4]));
  endproperty
  a_pin: assert property (p_pin)
    else $error("interrupt pin disagrees with enabled flags");

  property p_osc_pwr;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    !power_on |-> !osc_run;
  endproperty
  a_osc_pwr: assert property (p_osc_pwr)
    else $error("oscillator running without power");

  property p_sleep_stop;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (st_r.sleep && !int_i &&
     st_r.irq_sleep_cfg[aic_pkg::SLEEP_AFTER_IRQ_BIT]) |-> !osc_run;
  endproperty
  a_sleep_stop: assert property (p_sleep_stop)
    else $error("oscillator running in sleep after interrupt");

  property p_light_set;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    meas.light_event |=> st_r.status[aic_pkg::LIGHT_IRQ_BIT];
  endproperty
  a_light_set: assert property (p_light_set)
    else $error("light flag not set");

  property p_sat_w1c;
    @(posedge core_clk) disable iff (!rst_sync_b_r)
    (reg_req.wr && reg_req.addr == aic_pkg::STATUS_ADDR &&
     reg_req.wdata[aic_pkg::SATURATION_BIT] && !meas.sat_event)
    |=> !st_r.status[aic_pkg::SATURATION_BIT];
  endproperty
  a_sat_w1c: assert property (p_sat_w1c)
    else $error("saturation flag not cleared by write");

  c_sleep: cover property (@(posedge core_clk) disable iff (!rst_sync_b_r)
    $rose(st_r.sleep));
  c_wake: cover property (@(posedge core_clk) disable iff (!rst_sync_b_r)
    $fell(st_r.sleep));
  c_az: cover property (@(posedge core_clk) disable iff (!rst_sync_b_r)
    autozero_run);
  c_rdclr: cover property (@(posedge core_clk) disable iff (!rst_sync_b_r)
    read_status && st_r.irq_sleep_cfg[7] && |st_r.status);

endmodule // aic_ctrl

// ### aic_int_line.sv
// Host-side model of the open-drain interrupt wire with its pull-up.
`timescale 1ns/1ps

module aic_int_line
(
  input wire aic_pkg::aic_pin_type int_pin,
  output logic int_i
);
  // A released wire goes to the pull-up level, never to the last value.
  assign int_i = int_pin.int_oe ? int_pin.int_o : 1'h1;
endmodule // aic_int_line

// ### als_irq_sleep_autozero_ctrl_tb.sv
// Self-checking testbench for the interrupt, sleep and auto-zero block.
`timescale 1ns/1ps

module als_irq_sleep_autozero_ctrl_tb;
  logic core_clk;
  logic rst_b;
  logic power_on;
  aic_pkg::aic_reg_req_type reg_req;
  aic_pkg::aic_meas_type meas;
  aic_pkg::aic_pin_type int_pin;
  logic [7:0] reg_rdata;
  logic int_i;
  logic osc_run;
  logic autozero_run;
  logic start_from_prev;
  int failures;
  int comparisons;
  logic [7:0] az_cfg [3] = '{8'h83, 8'h00, 8'h7F};
  logic [6:0] az_pat [3] = '{7'h49, 7'h00, 7'h01};
  logic [7:0] m;

  aic_ctrl dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .power_on(power_on), .meas(meas),
    .int_pin(int_pin), .int_i(int_i), .osc_run(osc_run),
    .autozero_run(autozero_run), .start_from_prev(start_from_prev));

  aic_int_line line_u (.int_pin(int_pin), .int_i(int_i));

  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req.wr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req.rd <= 1'h0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  // Event pulses are sent one cycle wide, as the measurement logic does.
  task automatic ev(input logic [3:0] e);
    @(posedge core_clk);
    meas <= aic_pkg::aic_meas_type'(e);
    @(posedge core_clk);
    meas <= '0;
    #1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk);
    failures++;
    tally_and_finish;
  end

  initial
  begin
    rst_b = 1'h0;
    power_on = 1'h1;
    reg_req = '0;
    meas = '0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge core_clk);
    rd(aic_pkg::STATUS_ADDR, 8'h00);
    rd(aic_pkg::IRQ_SLEEP_CFG_ADDR, 8'h0C);
    rd(aic_pkg::AUTOZERO_CFG_ADDR, 8'h7F);
    rd(aic_pkg::IRQ_ENABLE_ADDR, 8'h00);
    rd(8'hA0, 8'h00);
    wr(aic_pkg::IRQ_SLEEP_CFG_ADDR, 8'h63);
    rd(aic_pkg::IRQ_SLEEP_CFG_ADDR, 8'h03);
    // Each source is first raised with its enable off, then enabled.
    for (int k = 0; k < 2; k++)
    begin
      m = k ? 8'h10 : 8'h80;
      wr(aic_pkg::IRQ_ENABLE_ADDR, 8'h00);
      ev(k ? 4'h4 : 4'h8);
      chk("int_oe", int_pin.int_oe, 8'h00);
      rd(aic_pkg::STATUS_ADDR, m);
      wr(aic_pkg::IRQ_ENABLE_ADDR, m);
      chk("int_oe", int_pin.int_oe, 8'h01);
      chk("int_o", int_pin.int_o, 8'h00);
      wr(aic_pkg::STATUS_ADDR, m);
      chk("int_oe", int_pin.int_oe, 8'h00);
      rd(aic_pkg::STATUS_ADDR, 8'h00);
    end
    wr(aic_pkg::IRQ_SLEEP_CFG_ADDR, 8'h8C);
    ev(4'hC);
    rd(aic_pkg::STATUS_ADDR, 8'h90);
    rd(aic_pkg::STATUS_ADDR, 8'h00);
    wr(aic_pkg::IRQ_SLEEP_CFG_ADDR, 8'h0C);
    ev(4'h4);
    rd(aic_pkg::STATUS_ADDR, 8'h10);
    rd(aic_pkg::STATUS_ADDR, 8'h10);
    ev(4'h1);
    chk("osc_run", osc_run, 8'h01);
    wr(aic_pkg::STATUS_ADDR, 8'h10);
    wr(aic_pkg::IRQ_ENABLE_ADDR, 8'h10);
    wr(aic_pkg::IRQ_SLEEP_CFG_ADDR, 8'h1C);
    ev(4'h4);
    chk("osc_run", osc_run, 8'h01);
    ev(4'h1);
    chk("osc_run", osc_run, 8'h00);
    rd(aic_pkg::IRQ_SLEEP_CFG_ADDR, 8'h1C);
    rd(aic_pkg::STATUS_ADDR, 8'h10);
    wr(aic_pkg::STATUS_ADDR, 8'h10);
    chk("int_oe", int_pin.int_oe, 8'h00);
    chk("osc_run", osc_run, 8'h01);
    @(posedge core_clk);
    #1;
    chk("osc_run", osc_run, 8'h01);
    @(posedge core_clk);
    power_on <= 1'h0;
    #1;
    chk("osc_run", osc_run, 8'h00);
    // A power cycle restarts the iteration count before each pattern.
    for (int i = 0; i < 3; i++)
    begin
      wr(aic_pkg::AUTOZERO_CFG_ADDR, az_cfg[i]);
      @(posedge core_clk);
      power_on <= 1'h0;
      @(posedge core_clk);
      power_on <= 1'h1;
      #1;
      chk("start_from_prev", start_from_prev, az_cfg[i][7]);
      for (int c = 0; c < 7; c++)
      begin
        ev(4'h2);
        chk("autozero_run", autozero_run, az_pat[i][c]);
      end
    end
    tally_and_finish;
  end
endmodule // als_irq_sleep_autozero_ctrl_tb
